/* File: src/windowed_watchdog_timer.sv */
// Windowed watchdog timer with Avalon-MM register slave
`timescale 1ns/10ps
`include "wdt_cfg.svh"
module windowed_watchdog_timer import wdt_pkg::*; #(
  parameter int LOW_POWER_RC_CLOCK_DIV = `WDT_LOW_POWER_RC_CLOCK_DIV,
  parameter int CNT_W = `WDT_CNT_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Non-volatile configuration
  input wire logic [7:0] watchdog_config_word_i,
  input wire logic [7:0] power_on_config_word_i,
  // Core events
  input wire logic wdt_clear_instr_i,
  input wire logic power_save_instr_i,
  input wire logic power_save_sleep_i,
  input wire logic osc_switch_done_i,
  input wire logic wake_other_i,
  // Watchdog outputs
  output logic wdt_reset_o,
  output logic core_wake_o,
  output logic low_power_rc_clock_on_o,
  output logic irq_o
);

  generate
    if (LOW_POWER_RC_CLOCK_DIV < 1 || LOW_POWER_RC_CLOCK_DIV > 4096) begin : g_chk_div
      $error("windowed_watchdog_timer: LOW_POWER_RC_CLOCK_DIV out of range");
    end
    if (CNT_W < `WDT_PRE_BITS_LONG + `WDT_POST_MAX_BITS || CNT_W > 32) begin : g_chk_cnt
      $error("windowed_watchdog_timer: CNT_W out of range");
    end
  endgenerate

  localparam logic [11:0] DIV_LAST = 12'(LOW_POWER_RC_CLOCK_DIV - 1);

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    return addr[4:2] == ofs[4:2];
  endfunction

  wdt_scale_if #(.CNT_W(CNT_W)) sif ();

  wdt_scaler #(.CNT_W(CNT_W)) u_scaler (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .sif(sif)
  );

  // Configuration capture
  logic [7:0] wdt_cfg_r;
  logic [7:0] por_cfg_r;
  logic cfg_loaded_r;

  // Reset control bits
  logic soft_en_r;
  logic soft_en_nxt;
  logic timeout_flag_r;
  logic timeout_flag_nxt;
  logic sleep_flag_r;
  logic sleep_flag_nxt;
  logic idle_flag_r;
  logic idle_flag_nxt;

  // Interrupt registers
  logic [`WDT_IRQ_W-1:0] irq_stat_r;
  logic [`WDT_IRQ_W-1:0] irq_stat_nxt;
  logic [`WDT_IRQ_W-1:0] irq_en_r;

  // RC clock divider and power state
  logic [11:0] div_cnt_r;
  logic [11:0] div_cnt_nxt;
  pwr_state_t pwr_r;
  pwr_state_t pwr_nxt;

  // Bus handshake
  logic wait_r;
  logic [31:0] rdata_nxt;

  // Output flops
  logic wdt_reset_r;
  logic core_wake_r;
  logic rc_on_r;
  logic irq_r;

  // Config decode
  // Reset image of the config word must not start the counter
  wire forced_on_w = cfg_loaded_r && wdt_cfg_r[`WDT_CFG_FORCED_BIT];
  wire window_disable_w = wdt_cfg_r[`WDT_CFG_WINDOW_DISABLE_BIT];
  wire prescale_select_w = wdt_cfg_r[`WDT_CFG_PRE_BIT];
  wire [3:0] postscale_select_w = wdt_cfg_r[`WDT_CFG_POST_MSB:`WDT_CFG_POST_LSB];

  wire enabled_w = forced_on_w || soft_en_r;

  // Bus decode
  wire req_w = read_i || write_i;
  wire take_w = req_w && !wait_r;
  wire wr_w = take_w && write_i && byteenable_i[0];
  wire wr_rc_w = wr_w && hit(address_i, `WDT_OFS_RESET_CTRL);
  wire wr_irq_clr_w = wr_w && hit(address_i, `WDT_OFS_IRQ_CLEAR);
  wire wr_irq_en_w = wr_w && hit(address_i, `WDT_OFS_IRQ_ENABLE);
  wire [7:0] wbyte_w = writedata_i[7:0];

  // Power state events
  wire running_w = (pwr_r == PWR_RUN);
  wire enter_ps_w = running_w && power_save_instr_i;
  wire expire_w = sif.expire;
  wire exit_ps_w = !running_w && (wake_other_i || expire_w);
  wire exit_other_w = !running_w && wake_other_i;

  wire early_clear_w = running_w && enabled_w && wdt_clear_instr_i && !window_disable_w && sif.early;
  // only window mode checks clear timing
  wire good_clear_w = running_w && wdt_clear_instr_i && !early_clear_w;
  wire run_timeout_w = running_w && expire_w;
  wire ps_timeout_w = !running_w && expire_w;
  wire fire_reset_w = run_timeout_w || early_clear_w;

  // RC tick from system clock divider
  wire rc_tick_w = enabled_w && (div_cnt_r == DIV_LAST);
  assign div_cnt_nxt = (!enabled_w || rc_tick_w) ? 12'h000 : div_cnt_r + 12'h001;

  // every restart source except a timeout clears counts
  // Timeout restarts by wrapping, so clear never depends on expire
  assign sif.clear = good_clear_w || early_clear_w || enter_ps_w || exit_other_w ||
                     osc_switch_done_i || !enabled_w;
  assign sif.tick = rc_tick_w;
  // counting needs the RC clock on
  assign sif.run = enabled_w;
  assign sif.pre_sel = prescale_select_w;
  assign sif.post_sel = postscale_select_w;

  // Power state machine
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PWR_RUN: begin
        if (power_save_instr_i) begin
          pwr_nxt = power_save_sleep_i ? PWR_SLEEP : PWR_IDLE;
        end
      end
      PWR_SLEEP, PWR_IDLE: begin
        if (exit_ps_w) begin
          pwr_nxt = PWR_RUN;
        end
      end
      default: begin
        pwr_nxt = PWR_RUN;
      end
    endcase
  end

  // Reset control register; hardware set wins over software clear
  always_comb begin
    soft_en_nxt = soft_en_r;
    timeout_flag_nxt = timeout_flag_r;
    sleep_flag_nxt = sleep_flag_r;
    idle_flag_nxt = idle_flag_r;
    if (wr_rc_w) begin
      soft_en_nxt = wbyte_w[`WDT_RC_SOFT_EN_BIT];
      sleep_flag_nxt = sleep_flag_r && wbyte_w[`WDT_RC_SLEEP_BIT];
      idle_flag_nxt = idle_flag_r && wbyte_w[`WDT_RC_IDLE_BIT];
      timeout_flag_nxt = timeout_flag_r && wbyte_w[`WDT_RC_TIMEOUT_BIT];
    end
    if (expire_w) begin
      timeout_flag_nxt = 1'b1;
    end
    if (enter_ps_w && power_save_sleep_i) begin
      sleep_flag_nxt = 1'b1;
    end
    if (enter_ps_w && !power_save_sleep_i) begin
      idle_flag_nxt = 1'b1;
    end
  end

  // Interrupt status: set beats write-one clear
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_irq_clr_w) begin
      irq_stat_nxt = irq_stat_r & ~wbyte_w[`WDT_IRQ_W-1:0];
    end
    if (expire_w) begin
      irq_stat_nxt[`WDT_IRQ_TIMEOUT_BIT] = 1'b1;
    end
    if (early_clear_w) begin
      irq_stat_nxt[`WDT_IRQ_EARLY_BIT] = 1'b1;
    end
    if (ps_timeout_w) begin
      irq_stat_nxt[`WDT_IRQ_WAKE_BIT] = 1'b1;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit(address_i, `WDT_OFS_RESET_CTRL)) begin
      rdata_nxt[`WDT_RC_SOFT_EN_BIT] = soft_en_r;
      rdata_nxt[`WDT_RC_TIMEOUT_BIT] = timeout_flag_r;
      rdata_nxt[`WDT_RC_SLEEP_BIT] = sleep_flag_r;
      rdata_nxt[`WDT_RC_IDLE_BIT] = idle_flag_r;
    end else if (hit(address_i, `WDT_OFS_WDT_CONFIG)) begin
      rdata_nxt[7:0] = wdt_cfg_r;
    end else if (hit(address_i, `WDT_OFS_POR_CONFIG)) begin
      rdata_nxt[7:0] = por_cfg_r;
    end else if (hit(address_i, `WDT_OFS_COUNT)) begin
      rdata_nxt[CNT_W-1:0] = sif.count;
    end else if (hit(address_i, `WDT_OFS_IRQ_STATUS)) begin
      rdata_nxt[`WDT_IRQ_W-1:0] = irq_stat_r;
    end else if (hit(address_i, `WDT_OFS_IRQ_ENABLE)) begin
      rdata_nxt[`WDT_IRQ_W-1:0] = irq_en_r;
    end
  end

  // Config words are sampled once after reset release, never under reset
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wdt_cfg_r <= `WDT_CFG_RST;
      por_cfg_r <= `WDT_POR_RST;
      cfg_loaded_r <= 1'b0;
    end else if (!cfg_loaded_r) begin
      wdt_cfg_r <= watchdog_config_word_i;
      por_cfg_r <= power_on_config_word_i;
      cfg_loaded_r <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      soft_en_r <= 1'b0;
      timeout_flag_r <= 1'b0;
      sleep_flag_r <= 1'b0;
      idle_flag_r <= 1'b0;
    end else begin
      soft_en_r <= soft_en_nxt;
      timeout_flag_r <= timeout_flag_nxt;
      sleep_flag_r <= sleep_flag_nxt;
      idle_flag_r <= idle_flag_nxt;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_stat_r <= '0;
      irq_en_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_irq_en_w) begin
        irq_en_r <= wbyte_w[`WDT_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_cnt_r <= 12'h000;
      pwr_r <= PWR_RUN;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      pwr_r <= pwr_nxt;
    end
  end

  // One wait cycle per access keeps read data a registered output
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_r <= 1'b1;
      readdata_o <= 32'h0000_0000;
    end else begin
      wait_r <= !(req_w && wait_r);
      if (req_w && wait_r) begin
        readdata_o <= rdata_nxt;
      end
    end
  end

  // Outputs from flops
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wdt_reset_r <= 1'b0;
      core_wake_r <= 1'b0;
      rc_on_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      // reset pulse on run-mode timeout or early clear; a power-save timeout pulses core_wake_o instead
      wdt_reset_r <= fire_reset_w;
      core_wake_r <= ps_timeout_w;
      rc_on_r <= forced_on_w || soft_en_nxt;
      irq_r <= |(irq_stat_nxt & irq_en_r);
    end
  end

  assign waitrequest_o = wait_r;
  assign wdt_reset_o = wdt_reset_r;
  assign core_wake_o = core_wake_r;
  assign low_power_rc_clock_on_o = rc_on_r;
  assign irq_o = irq_r;

endmodule

/* File: src/wdt_cfg.svh */
// Offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// Timing
`define WDT_CLK_HZ 25000000
`define WDT_LOW_POWER_RC_CLOCK_HZ 32000
`define WDT_LOW_POWER_RC_CLOCK_DIV (`WDT_CLK_HZ / `WDT_LOW_POWER_RC_CLOCK_HZ)
`define WDT_PRE_BITS_SHORT 5
`define WDT_PRE_BITS_LONG 7
`define WDT_POST_MAX_BITS 15
`define WDT_CNT_W 22

// Register byte offsets
`define WDT_OFS_RESET_CTRL 5'h00
`define WDT_OFS_WDT_CONFIG 5'h04
`define WDT_OFS_POR_CONFIG 5'h08
`define WDT_OFS_COUNT 5'h0C
`define WDT_OFS_IRQ_STATUS 5'h10
`define WDT_OFS_IRQ_CLEAR 5'h14
`define WDT_OFS_IRQ_ENABLE 5'h18

// Reset control fields
`define WDT_RC_SOFT_EN_BIT 5
`define WDT_RC_TIMEOUT_BIT 4
`define WDT_RC_SLEEP_BIT 3
`define WDT_RC_IDLE_BIT 2

// Watchdog config word fields
`define WDT_CFG_FORCED_BIT 7
`define WDT_CFG_WINDOW_DISABLE_BIT 6
`define WDT_CFG_PRE_BIT 4
`define WDT_CFG_POST_LSB 0
`define WDT_CFG_POST_MSB 3

// Interrupt status fields
`define WDT_IRQ_TIMEOUT_BIT 0
`define WDT_IRQ_EARLY_BIT 1
`define WDT_IRQ_WAKE_BIT 2
`define WDT_IRQ_W 3

// Reset values
`define WDT_CFG_RST 8'hFF
`define WDT_POR_RST 8'hFF

`endif

/* File: src/wdt_pkg.sv */
// Types shared by the watchdog modules
package wdt_pkg;
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SLEEP,
    PWR_IDLE
  } pwr_state_t;
endpackage

/* File: src/wdt_scale_if.sv */
// Carrier between watchdog control and its prescaler/postscaler counter
`timescale 1ns/10ps
interface wdt_scale_if #(parameter int CNT_W = 22);
  logic tick;
  logic clear;
  logic run;
  logic pre_sel;
  logic [3:0] post_sel;
  logic expire;
  logic early;
  logic [CNT_W-1:0] count;
  modport ctrl (output tick, output clear, output run, output pre_sel, output post_sel,
                input expire, input early, input count);
  modport scaler (input tick, input clear, input run, input pre_sel, input post_sel,
                  output expire, output early, output count);
endinterface

/* File: src/wdt_scaler.sv */
// Prescaler and postscaler chain counting low-power RC ticks
`timescale 1ns/10ps
`include "wdt_cfg.svh"
module wdt_scaler import wdt_pkg::*; #(
  parameter int CNT_W = `WDT_CNT_W
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Control side
  wdt_scale_if.scaler sif
);

  generate
    if (CNT_W < `WDT_PRE_BITS_LONG + `WDT_POST_MAX_BITS) begin : g_chk
      $error("wdt_scaler: CNT_W too small for longest period");
    end
  endgenerate

  // Last count of the selected period, prescaler bits low, postscaler above
  function automatic logic [CNT_W-1:0] last_count(input logic pre, input logic [3:0] post);
    int span;
    span = (pre ? `WDT_PRE_BITS_LONG : `WDT_PRE_BITS_SHORT) + int'(post);
    return CNT_W'((64'd1 << span) - 64'd1);
  endfunction

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  wire [CNT_W-1:0] last_w = last_count(sif.pre_sel, sif.post_sel);
  // three quarters of the period, taken from the last count so the longest period cannot wrap
  wire [CNT_W-1:0] thresh_w = last_w - (last_w >> 2);
  wire at_last_w = (cnt_r == last_w);

  assign sif.expire = sif.run && sif.tick && at_last_w && !sif.clear;
  // below threshold is an early clear
  assign sif.early = (cnt_r < thresh_w);
  assign sif.count = cnt_r;

  assign cnt_nxt = sif.clear ? '0 :
                   (!sif.run || !sif.tick) ? cnt_r :
                   at_last_w ? '0 : cnt_r + CNT_W'(1);

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

/* File: bench/windowed_watchdog_timer_monitor.sv */
// Checker on the watchdog's top-level ports
`timescale 1ns/10ps
module windowed_watchdog_timer_monitor #(
  parameter int LOW_POWER_RC_CLOCK_DIV = 781
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Bus handshake
  input wire logic read_i,
  input wire logic write_i,
  input wire logic waitrequest_o,
  // Watchdog
  input wire logic [7:0] watchdog_config_word_i,
  input wire logic wdt_clear_instr_i,
  input wire logic wdt_reset_o,
  input wire logic core_wake_o,
  input wire logic low_power_rc_clock_on_o
);
  // Small slack for tick phase at start
  localparam int MIN_TO = 32 * LOW_POWER_RC_CLOCK_DIV - 2;
  logic [15:0] age_r;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      age_r <= 16'h0000;
    else if (age_r != 16'hFFFF)
      age_r <= age_r + 16'h0001;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_req;
    $rose(read_i || write_i) && waitrequest_o;
  endsequence
  sequence s_ack;
    !waitrequest_o ##1 waitrequest_o;
  endsequence
  a_wait_one: assert property (s_req |=> s_ack)
    else $error("bus answer not one cycle");
  a_wait_cause: assert property (!waitrequest_o |-> $past(read_i || write_i))
    else $error("bus answer without request");
  a_reset_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("reset pulse too long");
  a_wake_pulse: assert property (core_wake_o |=> !core_wake_o && !wdt_reset_o)
    else $error("wake pulse wrong");
  a_early_reset: assert property (wdt_clear_instr_i && watchdog_config_word_i[7:6] == 2'b10 &&
    age_r >= 3 && age_r < 8 |=> wdt_reset_o)
    else $error("early clear gave no reset");
  a_forced_clock: assert property (watchdog_config_word_i[7] && age_r > 2 |-> low_power_rc_clock_on_o)
    else $error("forced-on clock off");
  a_min_timeout: assert property (wdt_reset_o && watchdog_config_word_i[6] |-> age_r >= MIN_TO)
    else $error("timeout too soon");
  a_clock_needed: assert property (wdt_reset_o |-> $past(low_power_rc_clock_on_o))
    else $error("reset with clock off");
endmodule

/* File: bench/windowed_watchdog_timer_bench.sv */
// Self-checking bench for the windowed watchdog
`timescale 1ns/10ps
module windowed_watchdog_timer_bench;
  // Short RC divide keeps runs brief
  localparam int DIV = 2;
  logic clock_i = 0, sys_rst_i = 1, read_i = 0, write_i = 0, ps_sleep = 0;
  logic [4:0] address_i = 5'h00;
  logic [31:0] writedata_i = 32'h0, rd, readdata_o;
  logic [7:0] cfg = 8'hC0;
  logic [7:0] tcfg [4] = '{8'hC0, 8'hC1, 8'hD0, 8'hD2};
  logic [3:0] ev = 4'b0000;
  logic waitrequest_o, wdt_reset_o, core_wake_o, low_power_rc_clock_on_o, irq_o;
  int err_count = 0, n_tests = 0, n, t;
  always #20 clock_i = ~clock_i;
  windowed_watchdog_timer #(.LOW_POWER_RC_CLOCK_DIV(DIV)) uut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .watchdog_config_word_i(cfg), .power_on_config_word_i(8'h5A),
    .wdt_clear_instr_i(ev[0]), .power_save_instr_i(ev[1]), .power_save_sleep_i(ps_sleep),
    .osc_switch_done_i(ev[2]), .wake_other_i(ev[3]), .wdt_reset_o(wdt_reset_o),
    .core_wake_o(core_wake_o), .low_power_rc_clock_on_o(low_power_rc_clock_on_o), .irq_o(irq_o));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    read_i <= !w;
    write_i <= w;
    address_i <= a;
    writedata_i <= d;
    @(posedge clock_i);
    while (waitrequest_o !== 1'b0) begin
      @(posedge clock_i);
    end
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic ev_pulse(input logic [3:0] m);
    ev <= m;
    @(posedge clock_i);
    ev <= 4'b0000;
  endtask
  task automatic wait_for(input logic wake_sel, input int lim);
    n = 0;
    while ((wake_sel ? core_wake_o : wdt_reset_o) !== 1'b1 && n < lim) begin
      @(posedge clock_i);
      n++;
    end
  endtask
  task automatic in_rng(input int lo, input int hi);
    check({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask
  // Config words are only sampled after reset
  task automatic restart(input logic [7:0] c);
    cfg <= c;
    sys_rst_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic finish_test;
    $display("mismatches=%0d comparisons=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    restart(8'h40);
    @(posedge clock_i);
    check({31'h0, low_power_rc_clock_on_o}, 32'h0);
    rd_chk(5'h00, 32'h0);
    rd_chk(5'h04, 32'h40);
    rd_chk(5'h1C, 32'h0);
    bus(1'b1, 5'h04, 32'h0);
    rd_chk(5'h04, 32'h40);
    bus(1'b1, 5'h18, 32'h7);
    bus(1'b1, 5'h00, 32'h20);
    @(posedge clock_i);
    check({31'h0, low_power_rc_clock_on_o}, 32'h1);
    wait_for(1'b0, 200);
    in_rng(56, 70);
    rd_chk(5'h00, 32'h30);
    check({31'h0, irq_o}, 32'h1);
    bus(1'b1, 5'h14, 32'h1);
    @(posedge clock_i);
    check({31'h0, irq_o}, 32'h0);
    bus(1'b1, 5'h00, 32'h0);
    @(posedge clock_i);
    check({31'h0, low_power_rc_clock_on_o}, 32'h0);
    wait_for(1'b0, 200);
    in_rng(200, 200);
    rd_chk(5'h00, 32'h0);
    bus(1'b1, 5'h00, 32'h20);
    restart(8'h80);
    repeat (2) @(posedge clock_i);
    ev_pulse(4'b0001);
    wait_for(1'b0, 4);
    in_rng(0, 2);
    rd_chk(5'h10, 32'h2);
    rd_chk(5'h00, 32'h0);
    bus(1'b1, 5'h00, 32'h0);
    @(posedge clock_i);
    check({31'h0, low_power_rc_clock_on_o}, 32'h1);
    // Clears one tick either side of the window edge
    for (int i = 0; i < 2; i++) begin
      restart(8'h80);
      repeat (46 + 2 * i) @(posedge clock_i);
      ev_pulse(4'b0001);
      wait_for(1'b0, 90);
      in_rng(i == 0 ? 0 : 60, i == 0 ? 2 : 68);
    end
    for (int i = 0; i < 4; i++) begin
      restart(tcfg[i]);
      t = DIV << ((tcfg[i][4] ? 7 : 5) + tcfg[i][3:0]);
      wait_for(1'b0, 2 * t);
      in_rng(t - 3, t + 4);
    end
    for (int i = 0; i < 3; i++) begin
      restart(8'hC0);
      ps_sleep <= 1'b1;
      if (i == 2) begin
        ev_pulse(4'b0010);
      end
      repeat (40) @(posedge clock_i);
      ev_pulse(i == 0 ? 4'b0001 : i == 1 ? 4'b0100 : 4'b1000);
      wait_for(1'b0, 100);
      in_rng(60, 68);
    end
    for (int i = 0; i < 2; i++) begin
      restart(8'hC0);
      ps_sleep <= (i == 0);
      ev_pulse(4'b0010);
      rd_chk(5'h00, i == 0 ? 32'h8 : 32'h4);
      wait_for(1'b1, 100);
      in_rng(55, 66);
      rd_chk(5'h10, 32'h5);
      rd_chk(5'h00, i == 0 ? 32'h18 : 32'h14);
      bus(1'b1, 5'h00, 32'h0);
      rd_chk(5'h00, 32'h0);
    end
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    finish_test();
  end
endmodule
bind windowed_watchdog_timer windowed_watchdog_timer_monitor #(.LOW_POWER_RC_CLOCK_DIV(LOW_POWER_RC_CLOCK_DIV)) mon (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .read_i(read_i), .write_i(write_i),
  .waitrequest_o(waitrequest_o), .watchdog_config_word_i(watchdog_config_word_i),
  .wdt_clear_instr_i(wdt_clear_instr_i), .wdt_reset_o(wdt_reset_o), .core_wake_o(core_wake_o),
  .low_power_rc_clock_on_o(low_power_rc_clock_on_o));
